// *** core/frame_fifo.sv ***
// Frame FIFO with registered read data and valid/ready on both sides
`timescale 1ns/10ps
module frame_fifo #(
  parameter int WIDTH = 44,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  // Storage ring feeds a single output register; total capacity is DEPTH
  logic [WIDTH-1:0] mem [DEPTH-1];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] ring_cnt_reg;
  logic [CNT_W-1:0] ring_cnt_next;
  logic [CNT_W-1:0] total_next;
  logic             push;
  logic             pop_ring;
  logic             out_free;

  // Handshake decode
  assign out_free      = ~out_valid_out | out_ready_in;
  assign push          = in_valid_in & in_ready_out;
  assign pop_ring      = (ring_cnt_reg != '0) & out_free;
  assign ring_cnt_next = ring_cnt_reg + CNT_W'(push) - CNT_W'(pop_ring);
  assign total_next    = ring_cnt_next + CNT_W'(out_valid_out & ~out_ready_in)
                       + CNT_W'(pop_ring);

  // Ring pointers and ready flag, ready kept in a flop for a clean port
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      ring_cnt_reg <= '0;
      in_ready_out <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH - 2)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop_ring) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH - 2)) ? '0 : rd_ptr_reg + 1'b1;
      end
      ring_cnt_reg <= ring_cnt_next;
      in_ready_out <= (total_next < CNT_W'(DEPTH));
    end
  end

  // Ring write, no reset needed on the array
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  // Output register holds the head word
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end else if (out_free) begin
      out_valid_out <= (ring_cnt_reg != '0);
      if (pop_ring) begin
        out_data_out <= mem[rd_ptr_reg];
      end
    end
  end
endmodule

// *** core/msg_object_ctrl.sv ***
// CAN message-object store: acceptance, remote answers, single transfer mode
//
// Operation
// - In single transfer mode a stored data or remote frame clears the object's valid bit.
// - An object invalidated after a single-transfer reception takes no more frames until rewritten.
// - In single transfer mode a successful transmission clears the object's valid bit.
// - Storing over unread data replaces it and sets the message-lost flag.
// - Outside single transfer mode a remote request is answered, possibly with repeated data; one arriving while a request is pending merges into it.
// - Data frames sent in answer never outnumber the remote requests received.
// - A remote frame hitting a transmit object sets its transmit request and clears new data.
`timescale 1ns/10ps
module msg_object_ctrl
  import mo_pkg::*;
#(
  parameter int NUM_OBJ = OBJ_COUNT,
  parameter int ID_W    = ID_WIDTH,
  parameter int DATA_W  = DATA_WIDTH,
  parameter int DEPTH   = FIFO_DEPTH,
  parameter int IDX_W   = (NUM_OBJ > 1) ? $clog2(NUM_OBJ) : 1
) (
  input  wire logic              CLK_IN,
  input  wire logic              RST_IN,
  // Software object write
  input  wire logic              SW_WR_IN,
  input  wire logic [IDX_W-1:0]  SW_IDX_IN,
  input  wire logic [ID_W-1:0]   SW_ID_IN,
  input  wire logic [DATA_W-1:0] SW_DATA_IN,
  input  wire logic              SW_DIR_IN,
  input  wire logic              SW_SINGLE_IN,
  input  wire logic              SW_VALID_IN,
  input  wire logic              SW_TRANSMIT_REQUEST_IN,
  input  wire logic              SW_NEW_DATA_FLAG_IN,
  // Software read of stored contents
  input  wire logic [IDX_W-1:0]  RD_IDX_IN,
  output logic [ID_W-1:0]        RD_ID_OUT,
  output logic [DATA_W-1:0]      RD_DATA_OUT,
  // Received frames from the protocol engine
  input  wire logic              RX_VALID_IN,
  output logic                   RX_READY_OUT,
  input  wire logic [ID_W-1:0]   RX_ID_IN,
  input  wire logic              RX_REMOTE_IN,
  input  wire logic [DATA_W-1:0] RX_DATA_IN,
  // Transmit offer to the protocol engine
  output logic                   TX_VALID_OUT,
  output logic [IDX_W-1:0]       TX_IDX_OUT,
  output logic [ID_W-1:0]        TX_ID_OUT,
  output logic                   TX_REMOTE_OUT,
  output logic [DATA_W-1:0]      TX_DATA_OUT,
  input  wire logic              TX_DONE_IN,
  input  wire logic              TX_ABORT_IN,
  // Per-object status
  output logic [NUM_OBJ-1:0]     OBJECT_VALID_OUT,
  output logic [NUM_OBJ-1:0]     NEW_DATA_FLAG_OUT,
  output logic [NUM_OBJ-1:0]     MESSAGE_LOST_FLAG_OUT,
  output logic [NUM_OBJ-1:0]     TRANSMIT_REQUEST_OUT
);
  localparam int FW = ID_W + 1 + DATA_W;

  // Object state; status ports are these flops directly
  logic [NUM_OBJ-1:0] dir_reg;
  logic [NUM_OBJ-1:0] single_transfer_mode;
  logic [ID_W-1:0]    id_reg   [NUM_OBJ];
  logic [DATA_W-1:0]  data_reg [NUM_OBJ];

  // Receive buffer wiring
  logic              head_valid;
  logic              head_take;
  logic [FW-1:0]     head_word;
  logic [ID_W-1:0]   head_id;
  logic              head_remote;
  logic [DATA_W-1:0] head_data;

  // Per-object decode
  logic [NUM_OBJ-1:0] match;
  logic [NUM_OBJ-1:0] rx_hit;
  logic [NUM_OBJ-1:0] sw_sel;
  logic [NUM_OBJ-1:0] tx_ok;
  logic [NUM_OBJ-1:0] tx_cand;
  logic [NUM_OBJ-1:0] tx_first;
  logic [IDX_W-1:0]   cand_idx;
  logic               offer_drop;

  tx_state_t state_reg;
  tx_state_t state_next;

  // Frames queue here so a software write can stall acceptance
  frame_fifo #(
    .WIDTH (FW),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .clk_in        (CLK_IN),
    .rst_in        (RST_IN),
    .in_valid_in   (RX_VALID_IN),
    .in_ready_out  (RX_READY_OUT),
    .in_data_in    ({RX_ID_IN, RX_REMOTE_IN, RX_DATA_IN}),
    .out_valid_out (head_valid),
    .out_ready_in  (~SW_WR_IN),
    .out_data_out  (head_word)
  );

  // Head decode; a software write takes the object store for one cycle
  assign head_id     = head_word[FW-1 -: ID_W];
  assign head_remote = head_word[DATA_W];
  assign head_data   = head_word[DATA_W-1:0];
  assign head_take   = head_valid & ~SW_WR_IN;

  // Lowest-numbered matching object wins acceptance
  assign rx_hit   = head_take ? (match & (~match + NUM_OBJ'(1))) : '0;
  // Lowest-numbered requesting object wins the transmit offer
  assign tx_cand  = OBJECT_VALID_OUT & TRANSMIT_REQUEST_OUT;
  assign tx_first = tx_cand & (~tx_cand + NUM_OBJ'(1));

  // One-hot to index for the offer latch
  always_comb begin
    cand_idx = '0;
    for (int k = 0; k < NUM_OBJ; k++) begin
      if (tx_first[k]) begin
        cand_idx = IDX_W'(k);
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_OBJ; g++) begin : g_obj
      // Invalid objects never match, so they stay deaf until rewritten
      assign match[g]  = OBJECT_VALID_OUT[g] & (id_reg[g] == head_id);
      assign sw_sel[g] = SW_WR_IN & (SW_IDX_IN == IDX_W'(g));
      assign tx_ok[g]  = (state_reg == TX_OFFER) & TX_DONE_IN & (TX_IDX_OUT == IDX_W'(g));

      // Later assignments win: a fresh remote request beats a finished answer
      always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
          OBJECT_VALID_OUT[g]      <= RST_FLAG;
          NEW_DATA_FLAG_OUT[g]     <= RST_FLAG;
          MESSAGE_LOST_FLAG_OUT[g] <= RST_FLAG;
          TRANSMIT_REQUEST_OUT[g]  <= RST_FLAG;
          dir_reg[g]               <= RST_DIR;
          single_transfer_mode[g]  <= RST_SINGLE;
          id_reg[g]                <= RST_ID;
          data_reg[g]              <= RST_DATA;
        end else if (sw_sel[g]) begin
          OBJECT_VALID_OUT[g]      <= SW_VALID_IN;
          NEW_DATA_FLAG_OUT[g]     <= SW_NEW_DATA_FLAG_IN;
          MESSAGE_LOST_FLAG_OUT[g] <= 1'b0;
          TRANSMIT_REQUEST_OUT[g]  <= SW_TRANSMIT_REQUEST_IN;
          dir_reg[g]               <= SW_DIR_IN;
          single_transfer_mode[g]  <= SW_SINGLE_IN;
          id_reg[g]                <= SW_ID_IN;
          data_reg[g]              <= SW_DATA_IN;
        end else begin
          if (tx_ok[g]) begin
            TRANSMIT_REQUEST_OUT[g] <= 1'b0;
            if (single_transfer_mode[g]) begin
              OBJECT_VALID_OUT[g] <= 1'b0;
            end
          end
          if (rx_hit[g] && head_remote && dir_reg[g]) begin
            TRANSMIT_REQUEST_OUT[g] <= 1'b1;
            NEW_DATA_FLAG_OUT[g]    <= 1'b0;
          end else if (rx_hit[g]) begin
            if (!head_remote) begin
              data_reg[g] <= head_data;
            end
            NEW_DATA_FLAG_OUT[g] <= 1'b1;
            if (NEW_DATA_FLAG_OUT[g]) begin
              MESSAGE_LOST_FLAG_OUT[g] <= 1'b1;
            end
            if (single_transfer_mode[g]) begin
              OBJECT_VALID_OUT[g] <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  // Offer withdrawn if software invalidates or cancels the object
  assign offer_drop = TX_DONE_IN | TX_ABORT_IN
                    | ~OBJECT_VALID_OUT[TX_IDX_OUT]
                    | ~TRANSMIT_REQUEST_OUT[TX_IDX_OUT];

  // Offer sequencing; an aborted frame returns to arbitration
  always_comb begin
    case (state_reg)
      TX_IDLE:  state_next = (|tx_first) ? TX_OFFER : TX_IDLE;
      TX_OFFER: state_next = offer_drop ? TX_IDLE : TX_OFFER;
      default:  state_next = TX_IDLE;
    endcase
  end

  // Payload latched at offer time so the engine sees a stable frame
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      state_reg     <= TX_IDLE;
      TX_VALID_OUT  <= 1'b0;
      TX_IDX_OUT    <= '0;
      TX_ID_OUT     <= RST_ID;
      TX_REMOTE_OUT <= 1'b0;
      TX_DATA_OUT   <= RST_DATA;
    end else begin
      state_reg    <= state_next;
      TX_VALID_OUT <= (state_next == TX_OFFER);
      if (state_reg == TX_IDLE && state_next == TX_OFFER) begin
        TX_IDX_OUT    <= cand_idx;
        TX_ID_OUT     <= id_reg[cand_idx];
        TX_REMOTE_OUT <= ~dir_reg[cand_idx]; // Receive objects ask by remote frame
        TX_DATA_OUT   <= data_reg[cand_idx];
      end
    end
  end

  // Registered read port, one cycle behind the index
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      RD_ID_OUT   <= RST_ID;
      RD_DATA_OUT <= RST_DATA;
    end else begin
      RD_ID_OUT   <= id_reg[RD_IDX_IN];
      RD_DATA_OUT <= data_reg[RD_IDX_IN];
    end
  end
endmodule

// *** inc/mo_pkg.sv ***
// Shared constants and types for the CAN message-object controller
package mo_pkg;

  // Structure defaults
  localparam int OBJ_COUNT   = 4;
  localparam int ID_WIDTH    = 11;
  localparam int DATA_WIDTH  = 32;
  localparam int FIFO_DEPTH  = 8;

  // Values after reset
  localparam logic RST_FLAG   = 1'h0;
  localparam logic RST_DIR    = 1'h0;
  localparam logic RST_SINGLE = 1'h0;
  localparam logic [ID_WIDTH-1:0]   RST_ID   = 11'h000;
  localparam logic [DATA_WIDTH-1:0] RST_DATA = 32'h0000_0000;

  // Transmit offer handshake towards the protocol engine
  typedef enum logic [0:0] {
    TX_IDLE  = 1'b0,
    TX_OFFER = 1'b1
  } tx_state_t;

endpackage

// *** verification/can_bus_model.sv ***
// Bus-side model: ends each transmit offer after a short or long delay
`timescale 1ns/10ps
module can_bus_model (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic tx_valid_in,
  input  wire logic tx_remote_in,
  input  wire logic slow_in,
  input  wire logic abort_in,
  output logic      done_out = 1'b0,
  output logic      abort_out = 1'b0,
  output int        data_frames_out = 0
);
  int wait_cnt = 0;
  // One-cycle end pulse; abort only while the bench asks for lost arbitration
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    abort_out <= 1'b0;
    if (rst_in || !tx_valid_in || done_out || abort_out) begin
      wait_cnt <= 0;
    end else if (wait_cnt == (slow_in ? 5 : 1)) begin
      done_out <= !abort_in;
      abort_out <= abort_in;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
    if (rst_in) data_frames_out <= 0;
    else if (done_out && !tx_remote_in) data_frames_out <= data_frames_out + 1;
  end
endmodule

// *** verification/msg_object_sva.sv ***
// Port assertions for the message-object controller
`timescale 1ns/10ps
module msg_object_sva #(
  parameter int NUM_OBJ = 4,
  parameter int IDX_W   = 2
) (
  input  wire logic               CLK_IN,
  input  wire logic               RST_IN,
  input  wire logic               SW_WR_IN,
  input  wire logic [IDX_W-1:0]   SW_IDX_IN,
  input  wire logic               SW_SINGLE_IN,
  input  wire logic               SW_VALID_IN,
  input  wire logic               SW_TRANSMIT_REQUEST_IN,
  input  wire logic               RX_READY_OUT,
  input  wire logic               TX_VALID_OUT,
  input  wire logic [IDX_W-1:0]   TX_IDX_OUT,
  input  wire logic               TX_DONE_IN,
  input  wire logic [NUM_OBJ-1:0] OBJECT_VALID_OUT,
  input  wire logic [NUM_OBJ-1:0] NEW_DATA_FLAG_OUT,
  input  wire logic [NUM_OBJ-1:0] MESSAGE_LOST_FLAG_OUT,
  input  wire logic [NUM_OBJ-1:0] TRANSMIT_REQUEST_OUT
);
  logic [NUM_OBJ-1:0] ov_q, rq_q, nd_q, ml_q, single_q;
  logic               sw_q;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // Last cycle's flags; single mode is shadowed since it is not visible
  always_ff @(posedge CLK_IN) begin
    ov_q <= OBJECT_VALID_OUT;
    rq_q <= TRANSMIT_REQUEST_OUT;
    nd_q <= NEW_DATA_FLAG_OUT;
    ml_q <= MESSAGE_LOST_FLAG_OUT;
    sw_q <= SW_WR_IN;
    if (RST_IN) single_q <= '0;
    else if (SW_WR_IN) single_q[SW_IDX_IN] <= SW_SINGLE_IN;
  end
  a_sw_write: assert property (SW_WR_IN |=> OBJECT_VALID_OUT[$past(SW_IDX_IN)] == $past(SW_VALID_IN)
    && TRANSMIT_REQUEST_OUT[$past(SW_IDX_IN)] == $past(SW_TRANSMIT_REQUEST_IN)) else $error("write not applied");
  a_single_rx_invalid: assert property (
    !sw_q |-> (NEW_DATA_FLAG_OUT & ~nd_q & single_q & OBJECT_VALID_OUT) == '0)
    else $error("single store kept object valid");
  a_valid_sticky: assert property (
    !SW_WR_IN |=> (OBJECT_VALID_OUT & ~ov_q) == '0)
    else $error("valid set by hardware");
  a_single_tx_invalid: assert property (
    TX_VALID_OUT && TX_DONE_IN && single_q[TX_IDX_OUT] && !SW_WR_IN
    |=> !OBJECT_VALID_OUT[$past(TX_IDX_OUT)])
    else $error("single send kept valid");
  a_lost_needs_data: assert property (
    !sw_q |-> (MESSAGE_LOST_FLAG_OUT & ~ml_q & ~nd_q) == '0)
    else $error("lost without old data");
  a_request_sticky: assert property (
    !SW_WR_IN && !(TX_VALID_OUT && TX_DONE_IN) |=> (rq_q & ~TRANSMIT_REQUEST_OUT) == '0)
    else $error("request dropped unsent");
  a_offer_from_valid: assert property (
    $rose(TX_VALID_OUT) |-> ov_q[TX_IDX_OUT] && rq_q[TX_IDX_OUT])
    else $error("offer from idle object");
  a_lowest_first: assert property ($rose(TX_VALID_OUT)
    |-> (ov_q & rq_q & ~({NUM_OBJ{1'b1}} << TX_IDX_OUT)) == '0) else $error("lower object skipped");
  a_offer_stable: assert property (TX_VALID_OUT && $past(TX_VALID_OUT) |-> $stable(TX_IDX_OUT))
    else $error("offer index moved");
  a_done_ends_offer: assert property (TX_VALID_OUT && TX_DONE_IN |=> !TX_VALID_OUT)
    else $error("offer held after done");
  // Main scenarios reached
  c_offer: cover property ($rose(TX_VALID_OUT));
  c_done: cover property (TX_VALID_OUT && TX_DONE_IN);
  c_full: cover property (!RX_READY_OUT);
endmodule
bind msg_object_ctrl msg_object_sva #(.NUM_OBJ(NUM_OBJ), .IDX_W(IDX_W)) sva_inst (
  .CLK_IN(CLK_IN), .RST_IN(RST_IN), .SW_WR_IN(SW_WR_IN), .SW_IDX_IN(SW_IDX_IN),
  .SW_SINGLE_IN(SW_SINGLE_IN), .SW_VALID_IN(SW_VALID_IN), .SW_TRANSMIT_REQUEST_IN(SW_TRANSMIT_REQUEST_IN),
  .RX_READY_OUT(RX_READY_OUT), .TX_VALID_OUT(TX_VALID_OUT), .TX_IDX_OUT(TX_IDX_OUT),
  .TX_DONE_IN(TX_DONE_IN), .OBJECT_VALID_OUT(OBJECT_VALID_OUT),
  .NEW_DATA_FLAG_OUT(NEW_DATA_FLAG_OUT), .MESSAGE_LOST_FLAG_OUT(MESSAGE_LOST_FLAG_OUT),
  .TRANSMIT_REQUEST_OUT(TRANSMIT_REQUEST_OUT));

// *** verification/tb.sv ***
// Self-checking bench for the message-object controller
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
  import mo_pkg::*;
  logic clk = 1'b0, rst = 1'b1, sw_wr = 1'b0, sw_dir = 1'b0, sw_single = 1'b0;
  logic sw_valid = 1'b0, sw_transmit_request = 1'b0, sw_new_data_flag = 1'b0, rx_valid = 1'b0;
  logic rx_remote = 1'b0, slow = 1'b0, abort = 1'b0, rx_ready, tx_remote, done, abrt, tx_valid;
  logic [1:0] sw_idx = 2'h0, rd_idx = 2'h0, tx_idx;
  logic [ID_WIDTH-1:0] sw_id = 11'h000, rx_id = 11'h000, rd_id, tx_id;
  logic [DATA_WIDTH-1:0] tx_data;
  logic [DATA_WIDTH-1:0] sw_data = 32'h0000_0000, rx_data = 32'h0000_0000, rd_data, d1, d2;
  logic [3:0] ov, nd, ml, rq;
  int mismatches = 0, num_checks = 0, frames, sent, n, k;
  msg_object_ctrl msg_object_ctrl_inst (.CLK_IN(clk), .RST_IN(rst), .SW_WR_IN(sw_wr),
    .SW_IDX_IN(sw_idx), .SW_ID_IN(sw_id), .SW_DATA_IN(sw_data), .SW_DIR_IN(sw_dir),
    .SW_SINGLE_IN(sw_single), .SW_VALID_IN(sw_valid), .SW_TRANSMIT_REQUEST_IN(sw_transmit_request),
    .SW_NEW_DATA_FLAG_IN(sw_new_data_flag), .RD_IDX_IN(rd_idx), .RD_ID_OUT(rd_id), .RD_DATA_OUT(rd_data),
    .RX_VALID_IN(rx_valid), .RX_READY_OUT(rx_ready), .RX_ID_IN(rx_id),
    .RX_REMOTE_IN(rx_remote), .RX_DATA_IN(rx_data), .TX_VALID_OUT(tx_valid),
    .TX_IDX_OUT(tx_idx), .TX_ID_OUT(tx_id), .TX_REMOTE_OUT(tx_remote),
    .TX_DATA_OUT(tx_data), .TX_DONE_IN(done),
    .TX_ABORT_IN(abrt), .OBJECT_VALID_OUT(ov), .NEW_DATA_FLAG_OUT(nd),
    .MESSAGE_LOST_FLAG_OUT(ml), .TRANSMIT_REQUEST_OUT(rq));
  can_bus_model can_bus_model_inst (.clk_in(clk), .rst_in(rst),
    .tx_valid_in(tx_valid), .tx_remote_in(tx_remote),
    .slow_in(slow), .abort_in(abort), .done_out(done), .abort_out(abrt),
    .data_frames_out(frames));
  // 25 MHz clock
  initial forever #20 clk = ~clk;
  // Expected flag vector with one object set
  function automatic logic [3:0] bit_of(input int i);
    return 4'h1 << i;
  endfunction
  task automatic stop_test;
    if (mismatches == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Whole-object write; f is {dir, single, valid, request, new data}
  task automatic wr(input logic [1:0] i, input logic [10:0] id, input logic [4:0] f);
    @(negedge clk);
    {sw_dir, sw_single, sw_valid, sw_transmit_request, sw_new_data_flag} = f;
    sw_idx = i;
    sw_id = id;
    sw_data = $urandom;
    sw_wr = 1'b1;
    @(negedge clk);
    sw_wr = 1'b0;
  endtask
  // Offer one frame and hold it until taken
  task automatic send(input logic [10:0] id, input logic rem, input logic [31:0] d);
    @(negedge clk);
    {rx_id, rx_remote, rx_data, rx_valid} = {id, rem, d, 1'b1};
    for (n = 0; n < 50 && !rx_ready; n++) @(negedge clk);
    if (n == 50) begin
      mismatches++;
      stop_test();
    end
    @(negedge clk);
    rx_valid = 1'b0;
  endtask
  task automatic rd(input logic [1:0] i, input logic [10:0] id, input logic [31:0] e);
    @(negedge clk);
    rd_idx = i;
    @(negedge clk);
    `CHK("stored id", id, rd_id)
    `CHK("stored data", e, rd_data)
  endtask
  initial begin
    n = $urandom(32'h5db6);
    repeat (6) @(negedge clk);
    rst = 1'b0;
    // Single-mode receiver and plain receiver, each addressed twice
    wr(0, 11'h101, 5'b01100);
    wr(1, 11'h202, 5'b00100);
    d1 = $urandom;
    d2 = $urandom;
    send(11'h101, 1'b0, d1);
    send(11'h101, 1'b0, d2);
    send(11'h202, 1'b0, d1);
    send(11'h202, 1'b0, d2);
    repeat (8) @(negedge clk);
    `CHK("valid", bit_of(1), ov)
    `CHK("lost", bit_of(1), ml)
    rd(0, 11'h101, d1);
    rd(1, 11'h202, d2);
    // Remote requests to a transmit object, answered by a slow bus
    wr(2, 11'h303, 5'b10101);
    d1 = sw_data;
    slow = 1'b1;
    send(11'h303, 1'b1, $urandom);
    for (k = 0; k < 20 && !rq[2]; k++) @(negedge clk);
    `CHK("request", 1'b1, rq[2])
    `CHK("new data", 1'b0, nd[2])
    // Offer follows one cycle after the request and carries the stored frame
    @(negedge clk);
    `CHK("offer", 3'h6, {tx_valid, tx_idx})
    `CHK("offer id", 11'h303, tx_id)
    `CHK("offer data", d1, tx_data)
    `CHK("offer kind", 1'b0, tx_remote)
    abort = 1'b1;
    repeat (12) @(negedge clk);
    abort = 1'b0;
    repeat (20) @(negedge clk);
    sent = 1;
    `CHK("answers", sent, frames)
    repeat ($urandom_range(1, 3)) begin
      send(11'h303, 1'b1, $urandom);
      sent++;
      repeat (20) @(negedge clk);
    end
    `CHK("answers", sent, frames)
    send(11'h303, 1'b1, $urandom);
    send(11'h303, 1'b1, $urandom);
    repeat (30) @(negedge clk);
    `CHK("answers", 1'b1, frames > sent && frames <= sent + 2)
    sent = frames;
    // Single-mode sender, then an invalid sender with a pending request
    wr(3, 11'h404, 5'b11110);
    repeat (20) @(negedge clk);
    `CHK("valid", bit_of(1) | bit_of(2), ov)
    wr(3, 11'h404, 5'b10010);
    send(11'h404, 1'b0, $urandom);
    repeat (20) @(negedge clk);
    `CHK("answers", sent + 1, frames)
    `CHK("new data", 1'b0, nd[3])
    // Receive object with a request asks by remote frame, never counted as an answer
    wr(1, 11'h202, 5'b00110);
    for (k = 0; k < 20 && !tx_valid; k++) @(negedge clk);
    `CHK("remote offer", 4'hd, {tx_valid, tx_remote, tx_idx})
    repeat (20) @(negedge clk);
    `CHK("answers", sent + 1, frames)
    // Software stall keeps the head full, so the ring must refuse the ninth frame
    {sw_wr, rx_id, rx_valid} = {1'b1, 11'h7ff, 1'b1};
    k = 0;
    repeat (12) begin
      k += rx_ready;
      @(negedge clk);
    end
    `CHK("accepted", 8, k)
    {sw_wr, rx_valid} = 2'b00;
    repeat (12) @(negedge clk);
    `CHK("ready", 1'b1, rx_ready)
    stop_test();
  end
endmodule
